//--- inc/kbc_consts.svh
// constants of the keyboard host interface: ports, addresses, status bits, timing
// assumes inclusion by bare name from the modules; the package and the interface do not include it
`ifndef KBC_CONSTS_SVH
`define KBC_CONSTS_SVH
// ----------------------------------------------------------------
// host i/o ports
// ----------------------------------------------------------------
`define KBC_PORT_DATA      16'h0060
`define KBC_PORT_CMD       16'h0064
// ----------------------------------------------------------------
// microcontroller data space
// ----------------------------------------------------------------
`define KBC_MC_DATA        16'h7FF1
`define KBC_MC_STATUS      16'h7FF2
`define KBC_MC_AUX_DATA    16'h7FFA
// ----------------------------------------------------------------
// status byte fields and reset
// ----------------------------------------------------------------
`define KBC_ST_OUT_FULL    0
`define KBC_ST_IN_FULL     1
`define KBC_ST_CD          3
`define KBC_ST_AUX         5
`define KBC_ST_FW_MASK     8'hD4
`define KBC_ST_RESET       8'h00
// ----------------------------------------------------------------
// controller registers (axi4-lite byte offsets)
// ----------------------------------------------------------------
`define KBC_R_CMD          5'h00
`define KBC_R_STAT         5'h04
`define KBC_R_IRQ_STATUS   5'h08
`define KBC_R_IRQ_CLEAR    5'h0C
`define KBC_R_IRQ_ENABLE   5'h10
`define KBC_CMD_OP_LSB     8
`define KBC_CMD_AEN_BIT    10
`define KBC_IRQ_DONE       0
`define KBC_IRQ_KBD        1
`define KBC_IRQ_MOUSE      2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define KBC_CLK_NS         10
`define KBC_STROBE_NS      100
`define KBC_STROBE_CYC     ((`KBC_STROBE_NS + `KBC_CLK_NS - 1) / `KBC_CLK_NS)
`endif

//--- inc/kbc_pkg.sv
// types used by the host end of the keyboard host interface; the device end does not import them
// assumes nothing beyond the compile order
package kbc_pkg;
  typedef enum logic [1:0]
  {
    OP_DATA_WR = 2'h0,
    OP_CMD_WR  = 2'h1,
    OP_DATA_RD = 2'h2,
    OP_STAT_RD = 2'h3
  } kbc_op_e;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'h0,
    ST_SETUP  = 2'h1,
    ST_STROBE = 2'h2,
    ST_HOLD   = 2'h3
  } kbc_state_e;
endpackage

//--- inc/kbc_if.sv
// host-side i/o bus between the host controller and the keyboard interface
// assumes both ends on one clock; the shared data wire is resolved here
`timescale 1ns/10ps
interface kbc_if;
  logic [15:0] addr;
  logic [7:0]  host_data;
  logic        iow_n;
  logic        ior_n;
  logic        aen;
  logic [7:0]  dev_data;
  logic        dev_data_oe;
  logic        keyboard_irq_out;
  logic        mouse_irq_out;
  logic [7:0]  bus_rd;

  // an undriven bus floats high
  assign bus_rd = dev_data_oe ? dev_data : 8'hFF;

  modport dev
  (
    input  addr,
    input  host_data,
    input  iow_n,
    input  ior_n,
    input  aen,
    output dev_data,
    output dev_data_oe,
    output keyboard_irq_out,
    output mouse_irq_out
  );

  modport host
  (
    output addr,
    output host_data,
    output iow_n,
    output ior_n,
    output aen,
    input  bus_rd,
    input  keyboard_irq_out,
    input  mouse_irq_out
  );
endinterface

//--- rtl/kbc_axil_slave.sv
// axi4-lite slave front end: turns bus cycles into register strobes
// assumes the parent answers rd_data combinationally from rd_addr
`timescale 1ns/10ps
module kbc_axil_slave
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_pulse,
  output logic [4:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic             rd_pulse,
  output logic [4:0]       rd_addr,
  input  wire logic [31:0] rd_data
);
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [4:0]  aw_addr_reg;
  logic [31:0] w_data_reg;

  assign awready  = !aw_got_reg && !bvalid;
  assign wready   = !w_got_reg && !bvalid;
  assign wr_pulse = aw_got_reg && w_got_reg;
  assign wr_addr  = aw_addr_reg;
  assign wr_data  = w_data_reg;
  assign bresp    = 2'h0;
  assign arready  = !rvalid;
  assign rd_pulse = arvalid && arready;
  assign rd_addr  = araddr;
  assign rresp    = 2'h0;

  // ----------------------------------------------------------------
  // write channel: address and data in either order
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg  <= 32'h0000_0000;
      bvalid      <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_reg <= 1'b1;
        // byte lanes not strobed write as zero; all fields are narrow
        w_data_reg <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end
      if (wr_pulse)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
    end
    else if (rd_pulse)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule

//--- rtl/kbc_dev_end.sv
// keyboard host interface, device end: host port decode, buffers, flags, irqs
// assumes host strobes and the microcontroller port are synchronous to aclk
//
// Contract
// [R1] port 60h: write data, read data buffer
// [R2] port 64h: write command, read status
// [R3] ignore host cycles while aen is high
// [R4] disabled interface answers no host port
// [R5] three bytes: status, write buffer, read buffer
// [R6] host data write: clear cd, set input full
// [R7] host command write: set cd, set input full
// [R8] host data read clears output full, irqs
// [R9] mc write 7FF1 loads data, full, kbd irq
// [R10] mc write 7FFA loads aux, mouse irq
// [R11] mc read 7FF1 returns buffer, clears input full
// [R12] status also at mc address 7FF2
// [R13] separate keyboard and mouse irq outputs
// [R14] status bits 0,1,3 fixed; rest firmware; the code also fixes bit 5 (aux full)
// [R15] input full raises gated mc interrupt, read clears
// [R16] gate bit low holds keyboard irq low
// [R17] reset clears flags and host irqs
`timescale 1ns/10ps
`include "kbc_consts.svh"
module kbc_dev_end
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  kbc_if.dev               isa,
  input  wire logic [15:0] mc_addr,
  input  wire logic        mc_wr,
  input  wire logic        mc_rd,
  input  wire logic [7:0]  mc_wdata,
  output logic [7:0]       mc_rdata,
  input  wire logic        kbd_enable,
  input  wire logic        output_irq_gate_enable,
  input  wire logic        input_full_irq_enable,
  output logic             input_full_interrupt
);
  logic       iow_prev_reg;
  logic       ior_prev_reg;
  logic [7:0] wr_buf_reg;
  logic [7:0] rd_buf_reg;
  logic [7:0] fw_bits_reg;
  logic       input_full_flag;
  logic       output_full_flag;
  logic       cd_flag;
  logic       aux_output_full_flag;
  logic       keyboard_output_irq_flag;
  logic       aux_output_irq_flag;
  logic [7:0] dev_data_reg;
  logic [7:0] status;
  logic       port_data;
  logic       port_cmd;
  logic       hit;
  logic       host_wr;
  logic       host_rd;
  logic       host_rd_data;
  logic       mc_wr_data;
  logic       mc_wr_aux;
  logic       mc_wr_stat;
  logic       mc_rd_data;

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  assign port_data = (isa.addr == `KBC_PORT_DATA);
  assign port_cmd  = (isa.addr == `KBC_PORT_CMD);
  assign hit       = kbd_enable && !isa.aen && (port_data || port_cmd); // [R3] [R4]
  // act once per strobe, on its leading edge
  assign host_wr      = hit && !isa.iow_n && iow_prev_reg;
  assign host_rd      = hit && !isa.ior_n && ior_prev_reg;
  assign host_rd_data = host_rd && port_data;

  // ----------------------------------------------------------------
  // microcontroller decode
  // ----------------------------------------------------------------
  assign mc_wr_data = mc_wr && (mc_addr == `KBC_MC_DATA);
  assign mc_wr_aux  = mc_wr && (mc_addr == `KBC_MC_AUX_DATA);
  assign mc_wr_stat = mc_wr && (mc_addr == `KBC_MC_STATUS);
  assign mc_rd_data = mc_rd && (mc_addr == `KBC_MC_DATA);

  // hardware bits fill the fixed positions, firmware the rest
  always_comb
  begin
    status               = fw_bits_reg & `KBC_ST_FW_MASK; // [R14]
    status[`KBC_ST_OUT_FULL] = output_full_flag;
    status[`KBC_ST_IN_FULL]  = input_full_flag;
    status[`KBC_ST_CD]       = cd_flag;
    status[`KBC_ST_AUX]      = aux_output_full_flag;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      iow_prev_reg <= 1'b1;
      ior_prev_reg <= 1'b1;
    end
    else
    begin
      iow_prev_reg <= isa.iow_n;
      ior_prev_reg <= isa.ior_n;
    end
  end

  // ----------------------------------------------------------------
  // write buffer and command/data flag
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_buf_reg <= 8'h00;
      cd_flag    <= 1'b0; // [R17]
    end
    else if (host_wr)
    begin
      wr_buf_reg <= isa.host_data; // [R5]
      cd_flag    <= port_cmd; // [R6] [R7]
    end
  end

  // a host write in the same cycle as the mc read keeps the flag set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      input_full_flag <= 1'b0; // [R17]
    else if (host_wr)
      input_full_flag <= 1'b1; // [R6] [R7]
    else if (mc_rd_data)
      input_full_flag <= 1'b0; // [R11]
  end

  assign input_full_interrupt = input_full_flag && input_full_irq_enable; // [R15]

  // ----------------------------------------------------------------
  // read buffer and output flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_buf_reg <= 8'h00;
    else if (mc_wr_data || mc_wr_aux)
      rd_buf_reg <= mc_wdata; // [R9] [R10]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      output_full_flag <= 1'b0; // [R17]
    else if (mc_wr_data || mc_wr_aux)
      output_full_flag <= 1'b1; // [R9] [R10]
    else if (host_rd_data)
      output_full_flag <= 1'b0; // [R8]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aux_output_full_flag <= 1'b0;
    else if (mc_wr_aux)
      aux_output_full_flag <= 1'b1; // [R10]
    else if (mc_wr_data)
      aux_output_full_flag <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      keyboard_output_irq_flag <= 1'b0; // [R17]
    else if (mc_wr_data)
      keyboard_output_irq_flag <= 1'b1; // [R9]
    else if (host_rd_data)
      keyboard_output_irq_flag <= 1'b0; // [R8]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aux_output_irq_flag <= 1'b0; // [R17]
    else if (mc_wr_aux)
      aux_output_irq_flag <= 1'b1; // [R10]
    else if (host_rd_data)
      aux_output_irq_flag <= 1'b0; // [R8]
  end

  // both lines share one gate bit
  assign isa.keyboard_irq_out = output_irq_gate_enable && keyboard_output_irq_flag; // [R13] [R16]
  assign isa.mouse_irq_out    = output_irq_gate_enable && aux_output_irq_flag; // [R13]

  // ----------------------------------------------------------------
  // firmware status bits
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fw_bits_reg <= `KBC_ST_RESET;
    else if (mc_wr_stat)
      fw_bits_reg <= mc_wdata & `KBC_ST_FW_MASK; // [R14]
  end

  // ----------------------------------------------------------------
  // host read data: latched at the strobe's leading edge
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dev_data_reg <= 8'h00;
    else if (host_rd)
      dev_data_reg <= port_data ? rd_buf_reg : status; // [R1] [R2] [R12]
  end

  assign isa.dev_data    = dev_data_reg;
  // drive only once the latch holds the selected byte
  assign isa.dev_data_oe = hit && !isa.ior_n && !ior_prev_reg;

  // ----------------------------------------------------------------
  // microcontroller read port, one cycle behind the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mc_rdata <= 8'h00;
    else if (mc_rd)
    begin
      if (mc_addr == `KBC_MC_DATA)
        mc_rdata <= wr_buf_reg; // [R11]
      else if (mc_addr == `KBC_MC_STATUS)
        mc_rdata <= status; // [R12]
      else
        mc_rdata <= 8'h00;
    end
  end
endmodule

//--- rtl/kbc_host_end.sv
// keyboard host interface, host end: runs host i/o cycles ordered over axi4-lite
// assumes the device end answers reads within the strobe
`timescale 1ns/10ps
`include "kbc_consts.svh"
module kbc_host_end
#(
  parameter int STROBE_CYC = `KBC_STROBE_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  kbc_if.host              isa,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq
);
  logic               wr_pulse;
  logic [4:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [4:0]         rd_addr;
  logic [31:0]        rd_data;
  kbc_pkg::kbc_state_e state_reg;
  kbc_pkg::kbc_op_e    op_reg;
  logic [7:0]         cnt_reg;
  logic [7:0]         rd_byte_reg;
  logic [2:0]         irq_st_reg;
  logic [2:0]         irq_en_reg;
  logic               kbd_irq_prev_reg;
  logic               mouse_irq_prev_reg;
  logic [2:0]         events;
  logic               start;

  kbc_axil_slave u_axil
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_pulse (),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // a command written while busy is dropped
  assign start = wr_pulse && (wr_addr == `KBC_R_CMD) && (state_reg == kbc_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // i/o cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= kbc_pkg::ST_IDLE;
      op_reg        <= kbc_pkg::OP_DATA_WR;
      cnt_reg       <= 8'h00;
      isa.addr      <= 16'h0000;
      isa.host_data <= 8'h00;
      isa.aen       <= 1'b0;
      isa.iow_n     <= 1'b1;
      isa.ior_n     <= 1'b1;
      rd_byte_reg   <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        kbc_pkg::ST_IDLE:
        begin
          if (start)
          begin
            op_reg        <= kbc_pkg::kbc_op_e'(wr_data[`KBC_CMD_OP_LSB+1:`KBC_CMD_OP_LSB]);
            isa.host_data <= wr_data[7:0];
            isa.aen       <= wr_data[`KBC_CMD_AEN_BIT];
            // op bit 0 selects the command/status port
            isa.addr      <= wr_data[`KBC_CMD_OP_LSB] ? `KBC_PORT_CMD : `KBC_PORT_DATA; // [R1] [R2]
            state_reg     <= kbc_pkg::ST_SETUP;
          end
        end
        kbc_pkg::ST_SETUP:
        begin
          cnt_reg   <= 8'(STROBE_CYC - 1);
          isa.iow_n <= op_reg[1];
          isa.ior_n <= !op_reg[1];
          state_reg <= kbc_pkg::ST_STROBE;
        end
        kbc_pkg::ST_STROBE:
        begin
          if (cnt_reg == 8'h00)
          begin
            if (op_reg[1])
              rd_byte_reg <= isa.bus_rd;
            isa.iow_n <= 1'b1;
            isa.ior_n <= 1'b1;
            state_reg <= kbc_pkg::ST_HOLD;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        kbc_pkg::ST_HOLD:
        begin
          isa.aen   <= 1'b0;
          state_reg <= kbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kbd_irq_prev_reg   <= 1'b0;
      mouse_irq_prev_reg <= 1'b0;
    end
    else
    begin
      kbd_irq_prev_reg   <= isa.keyboard_irq_out;
      mouse_irq_prev_reg <= isa.mouse_irq_out;
    end
  end

  always_comb
  begin
    events                 = 3'h0;
    events[`KBC_IRQ_DONE]  = (state_reg == kbc_pkg::ST_HOLD);
    events[`KBC_IRQ_KBD]   = isa.keyboard_irq_out && !kbd_irq_prev_reg;
    events[`KBC_IRQ_MOUSE] = isa.mouse_irq_out && !mouse_irq_prev_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_st_reg <= 3'h0;
    else if (wr_pulse && (wr_addr == `KBC_R_IRQ_CLEAR))
      irq_st_reg <= (irq_st_reg & ~wr_data[2:0]) | events;
    else
      irq_st_reg <= irq_st_reg | events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_en_reg <= 3'h0;
    else if (wr_pulse && (wr_addr == `KBC_R_IRQ_ENABLE))
      irq_en_reg <= wr_data[2:0];
  end

  assign irq = |(irq_st_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `KBC_R_STAT:
        rd_data = {14'h0000, isa.mouse_irq_out, isa.keyboard_irq_out,
                   rd_byte_reg, 7'h00, (state_reg != kbc_pkg::ST_IDLE)};
      `KBC_R_IRQ_STATUS: rd_data = {29'h0000_0000, irq_st_reg};
      `KBC_R_IRQ_ENABLE: rd_data = {29'h0000_0000, irq_en_reg};
      default:           rd_data = 32'h0000_0000;
    endcase
  end
endmodule

//--- dv/kbc_link_monitor.sv
// checker beside the host i/o link of the keyboard host interface
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`include "kbc_consts.svh"
module kbc_link_monitor
#(
  parameter int STROBE_CYC = `KBC_STROBE_CYC
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] addr,
  input wire logic [7:0]  host_data,
  input wire logic        iow_n,
  input wire logic        ior_n,
  input wire logic        aen,
  input wire logic        dev_data_oe,
  input wire logic        keyboard_irq_out,
  input wire logic        mouse_irq_out
);
  logic [7:0] low_cnt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----
  // strobe length counter
  // ----
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (iow_n && ior_n))
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end

  // ----
  // link properties
  // ----
  aen_quiet_a: assert property (aen |-> !dev_data_oe)
    else $error("data driven in a flagged cycle");
  oe_port_a: assert property (dev_data_oe |-> !ior_n &&
    (addr == `KBC_PORT_DATA || addr == `KBC_PORT_CMD))
    else $error("data driven outside a port read");
  write_no_oe_a: assert property (!iow_n |-> !dev_data_oe)
    else $error("data driven during a write");
  strobe_excl_a: assert property (!(!iow_n && !ior_n))
    else $error("both strobes low");
  strobe_len_a: assert property ($rose(iow_n && ior_n) |-> low_cnt == 8'(STROBE_CYC))
    else $error("strobe length wrong");
  read_clr_a: assert property ($fell(ior_n) && !aen && addr == `KBC_PORT_DATA
    |=> !keyboard_irq_out && !mouse_irq_out)
    else $error("irq kept after data read");
  reset_quiet_a: assert property ($rose(aresetn)
    |-> !keyboard_irq_out && !mouse_irq_out && !dev_data_oe)
    else $error("irq or data after reset");
  write_hold_a: assert property (!iow_n && !$past(iow_n)
    |-> $stable(host_data) && $stable(addr))
    else $error("write payload moved in strobe");
endmodule

//--- dv/kbc_host_interface_bench.sv
// bench: host end and device end joined by the link
// assumes strobe shortened to 2 cycles; microcontroller port driven here
`timescale 1ns/10ps
`include "kbc_consts.svh"
module kbc_host_interface_bench;
  localparam int SC = 2;
  typedef struct packed
  {
    logic [1:0]  kind;
    logic [15:0] a;
    logic [7:0]  d;
    logic [9:0]  exp;
    logic [9:0]  msk;
  } kbc_row_s;
  logic aclk, aresetn, mc_wr, mc_rd, kbd_enable, output_irq_gate_enable;
  logic input_full_irq_enable, input_full_interrupt, irq;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [15:0] mc_addr;
  logic [7:0]  mc_wdata, mc_rdata;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          bad_count = 0;
  int          n_checks = 0;
  kbc_row_s    r;
  // kinds: 0 mc write, 1 mc read, 2 host cycle (a holds the op)
  kbc_row_s rows [18] = '{
    '{2'h2, 16'h0, 8'hA5, 10'h000, 10'h300}, '{2'h1, 16'h7FF2, 8'h0, 10'h102, 10'h1FF},
    '{2'h1, 16'h7FF1, 8'h0, 10'h0A5, 10'h1FF}, '{2'h1, 16'h7FF2, 8'h0, 10'h000, 10'h1FF},
    '{2'h2, 16'h1, 8'h3C, 10'h000, 10'h300}, '{2'h1, 16'h7FF2, 8'h0, 10'h10A, 10'h1FF},
    '{2'h1, 16'h7FF1, 8'h0, 10'h03C, 10'h1FF}, '{2'h0, 16'h7FF1, 8'h5A, 10'h0, 10'h0},
    '{2'h2, 16'h3, 8'h0, 10'h109, 10'h3FF}, '{2'h2, 16'h2, 8'h0, 10'h05A, 10'h3FF},
    '{2'h2, 16'h3, 8'h0, 10'h008, 10'h3FF}, '{2'h0, 16'h7FFA, 8'hC3, 10'h0, 10'h0},
    '{2'h2, 16'h3, 8'h0, 10'h229, 10'h3FF}, '{2'h2, 16'h2, 8'h0, 10'h0C3, 10'h3FF},
    '{2'h2, 16'h3, 8'h0, 10'h028, 10'h3FF}, '{2'h0, 16'h7FF2, 8'hFF, 10'h0, 10'h0},
    '{2'h1, 16'h7FF2, 8'h0, 10'h0FC, 10'h1FF}, '{2'h0, 16'h7FF2, 8'h00, 10'h0, 10'h0}};

  kbc_if isa();
  kbc_dev_end kbc_dev_end_i(.aclk, .aresetn, .isa(isa), .mc_addr, .mc_wr, .mc_rd,
    .mc_wdata, .mc_rdata, .kbd_enable, .output_irq_gate_enable, .input_full_irq_enable,
    .input_full_interrupt);
  kbc_host_end #(.STROBE_CYC(SC)) kbc_host_end_i(.aclk, .aresetn, .isa(isa), .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
  kbc_link_monitor #(.STROBE_CYC(SC)) kbc_link_monitor_i(.aclk, .aresetn,
    .addr(isa.addr), .host_data(isa.host_data), .iow_n(isa.iow_n), .ior_n(isa.ior_n),
    .aen(isa.aen), .dev_data_oe(isa.dev_data_oe),
    .keyboard_irq_out(isa.keyboard_irq_out), .mouse_irq_out(isa.mouse_irq_out));

  // ----
  // shared tasks
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk(bresp, 2'h0);
    bready <= 1'b0;
  endtask
  task axr(input logic [4:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    chk(rresp, 2'h0);
    rready <= 1'b0;
  endtask
  // one host i/o cycle, then poll until the host end is idle again
  task hop(input logic [1:0] op, input logic [7:0] d, input logic fl, output logic [31:0] s);
    axw(`KBC_R_CMD, {21'h0, fl, op, d});
    do
      axr(`KBC_R_STAT, s);
    while (s[0] !== 1'b0);
  endtask
  task mcx(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    mc_addr <= a;
    mc_wdata <= d;
    mc_wr <= w;
    mc_rd <= !w;
    @(posedge aclk);
    mc_wr <= 1'b0;
    mc_rd <= 1'b0;
    @(posedge aclk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----
  // clock, watchdog, sequence
  // ----
  initial
  begin
    aclk = 1'b0;
    forever
      #5 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    conclude();
  end
  initial
  begin
    {aresetn, mc_wr, mc_rd, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {kbd_enable, output_irq_gate_enable, input_full_irq_enable} = 3'h7;
    {mc_addr, mc_wdata, awaddr, araddr, wdata} = 66'h0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      if (r.kind == 2'h2)
      begin
        hop(r.a[1:0], r.d, 1'b0, st);
        chk(st[17:8] & r.msk, r.exp);
      end
      else
      begin
        mcx(r.kind == 2'h0, r.a, r.d);
        if (r.kind == 2'h1)
          chk({input_full_interrupt, mc_rdata} & r.msk, r.exp);
      end
    end
    $display("table done");
    // second reset while a byte waits for the host
    mcx(1'b1, `KBC_MC_DATA, 8'hAA);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    mcx(1'b0, `KBC_MC_STATUS, 8'h00);
    chk({isa.keyboard_irq_out, isa.mouse_irq_out, mc_rdata}, 10'h000);
    $display("reset done");
    output_irq_gate_enable <= 1'b0;
    mcx(1'b1, `KBC_MC_DATA, 8'h11);
    chk({isa.keyboard_irq_out, isa.mouse_irq_out}, 2'b00);
    output_irq_gate_enable <= 1'b1;
    @(posedge aclk);
    chk(isa.keyboard_irq_out, 1'b1);
    hop(2'h2, 8'h00, 1'b0, st);
    chk(st[17:8], 10'h011);
    $display("gate done");
    // input-full interrupt follows its enable; the mc read clears it
    input_full_irq_enable <= 1'b0;
    hop(2'h0, 8'h77, 1'b0, st);
    chk(input_full_interrupt, 1'b0);
    input_full_irq_enable <= 1'b1;
    @(posedge aclk);
    chk(input_full_interrupt, 1'b1);
    mcx(1'b0, `KBC_MC_DATA, 8'h00);
    chk({input_full_interrupt, mc_rdata}, 9'h077);
    $display("input gate done");
    // first pass disabled, second pass with the cycle flagged
    for (int j = 0; j < 2; j++)
    begin
      kbd_enable <= j[0];
      hop(2'h1, 8'h66, j[0], st);
      hop(2'h3, 8'h00, j[0], st);
      chk(st[15:8], 8'hFF);
      mcx(1'b0, `KBC_MC_STATUS, 8'h00);
      chk(mc_rdata, 8'h00);
    end
    $display("ignore done");
    axr(`KBC_R_IRQ_STATUS, st);
    chk({st[2:0], irq}, 4'h6);
    axw(`KBC_R_IRQ_ENABLE, 32'h1);
    @(posedge aclk);
    chk(irq, 1'b1);
    axw(`KBC_R_IRQ_CLEAR, 32'h7);
    @(posedge aclk);
    chk(irq, 1'b0);
    axr(5'h14, st);
    chk(st, 32'h0);
    $display("irq done");
    conclude();
  end
endmodule
